// *** pkg/ilod_pkg.sv ***
package ilod_pkg;
    // register byte offsets on the apb side
    localparam logic [7:0]  OFF_CTRL     = 8'h00;
    localparam logic [7:0]  OFF_FP       = 8'h04;
    localparam logic [7:0]  OFF_BANK     = 8'h08;
    localparam logic [7:0]  OFF_RETTOP   = 8'h0c;
    localparam logic [7:0]  OFF_INSTR    = 8'h10;
    localparam logic [7:0]  OFF_ADDR     = 8'h14;
    localparam logic [7:0]  OFF_PC       = 8'h18;
    localparam logic [7:0]  OFF_STAT     = 8'h1c;
    // field positions
    localparam int          CTRL_EXT_BIT = 0;
    localparam int          ACC_BIT      = 8;
    localparam int          DEST_BIT     = 9;
    // reset values
    localparam logic        EXT_RST      = 1'b0;
    localparam logic [11:0] FP_RST       = 12'h000;
    localparam logic [3:0]  BANK_RST     = 4'h0;
    localparam logic [15:0] RETTOP_RST   = 16'h0000;
    localparam logic [15:0] PC_RST       = 16'h0000;
    localparam logic [11:0] ADDR_RST     = 12'h000;
    // opcode decode constants
    localparam logic [7:0]  PSUB_HI      = 8'he9;   // pointer-subtract opcode byte
    localparam logic [1:0]  SEL_RETURN   = 2'b11;   // frame pointer plus return
    localparam logic [7:0]  OFFSET_MAX   = 8'h5f;   // largest indexed operand
    localparam logic [3:0]  ACC_HI_BANK  = 4'hf;    // upper half of access bank
    localparam logic [3:0]  NIB_FIRST    = 4'h1;
    localparam logic [3:0]  NIB_LAST     = 4'hb;
    localparam logic [3:0]  NIB_BIT_LO   = 4'h7;

    typedef struct packed {
        logic        valid;
        logic [15:0] word;
    } ilod_instr_t;

    typedef struct packed {
        logic        valid;     // one-cycle pulse per file access
        logic [11:0] addr;
        logic        destToW;
        logic        indexed;
    } ilod_mem_t;
endpackage : ilod_pkg

// *** rtl/ilod_decode.sv ***
`timescale 1ns/1ps
module ilod_decode (
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    input  wire ilod_pkg::ilod_instr_t coreInstr,
    output logic                      instrReady,
    output ilod_pkg::ilod_mem_t       memReq,
    output logic                      pcLoad,
    output logic [15:0]               pcNext,
    output logic [11:0]               framePointer,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr
);
    logic                extEn_q;
    logic [11:0]         fp_q;
    logic [3:0]          bank_q;
    logic [15:0]         retTop_q;
    logic [15:0]         instr_q;
    logic                busy_q;
    logic                ready_q;
    logic                lastRet_q;
    ilod_pkg::ilod_mem_t mem_q;
    logic                pcLoad_q;
    logic [15:0]         pc_q;
    logic [31:0]         prdata_q;
    logic                pready_q;
    logic                pslverr_q;

    // operand address: indexed, access bank or banked
    function automatic logic [11:0] effAddr(input logic [15:0] w, input logic ext,
                                            input logic [11:0] fp, input logic [3:0] bank);
        logic [7:0] f;
        f = w[7:0];
        if (w[ilod_pkg::ACC_BIT]) begin
            effAddr = {bank, f};
        end else if (ext && f <= ilod_pkg::OFFSET_MAX) begin
            effAddr = 12'(fp + {4'h0, f});
        end else if (f <= ilod_pkg::OFFSET_MAX) begin
            effAddr = {4'h0, f};
        end else begin
            effAddr = {ilod_pkg::ACC_HI_BANK, f};
        end
    endfunction : effAddr

    // apb phase decode
    // a write lands only at the edge where the access phase meets ready
    wire         apbSetup  = psel && !penable;
    wire         apbDone   = psel && penable && pready_q;
    wire         apbWr     = apbDone && pwrite;
    wire         mapped    = (paddr[1:0] == 2'b00) && (paddr <= ilod_pkg::OFF_STAT);
    wire         wrCtrl    = apbWr && paddr == ilod_pkg::OFF_CTRL;
    wire         wrFp      = apbWr && paddr == ilod_pkg::OFF_FP;
    wire         wrBank    = apbWr && paddr == ilod_pkg::OFF_BANK;
    wire         wrRet     = apbWr && paddr == ilod_pkg::OFF_RETTOP;
    wire         wrInstr   = apbWr && paddr == ilod_pkg::OFF_INSTR;

    // issue: the core port wins; a register issue meeting it is dropped
    wire         issueValid = !busy_q && (coreInstr.valid || wrInstr);
    wire [15:0]  issueWord  = coreInstr.valid ? coreInstr.word : pwdata[15:0];

    // class decode
    wire         isPsub     = issueWord[15:8] == ilod_pkg::PSUB_HI;
    wire         isSubRet   = isPsub && issueWord[7:6] == ilod_pkg::SEL_RETURN;
    wire [3:0]   nib        = issueWord[15:12];
    // nibble 0 with bits 11:9 clear holds control ops with no file operand
    wire         isFileOp   = (nib >= ilod_pkg::NIB_FIRST && nib <= ilod_pkg::NIB_LAST)
                              || (nib == 4'h0 && issueWord[11:9] != 3'b000);
    wire         isBitOp    = nib >= ilod_pkg::NIB_BIT_LO;
    wire [5:0]   lit        = issueWord[5:0];
    // unsigned literal; a borrow past bit 11 wraps like the pointer itself
    wire [11:0]  fpSub      = fp_q - {6'h00, lit};
    wire [11:0]  addrNext   = effAddr(issueWord, extEn_q, fp_q, bank_q);
    wire         idxNext    = extEn_q && !issueWord[ilod_pkg::ACC_BIT]
                              && issueWord[7:0] <= ilod_pkg::OFFSET_MAX;
    // bit ops write back to the file; byte ops obey the destination bit
    wire         toWNext    = !isBitOp && !issueWord[ilod_pkg::DEST_BIT];

    // read mux
    logic [31:0] rdMux;
    always_comb begin
        case (paddr)
            ilod_pkg::OFF_CTRL:   rdMux = {31'h0, extEn_q};
            ilod_pkg::OFF_FP:     rdMux = {20'h0, fp_q};
            ilod_pkg::OFF_BANK:   rdMux = {28'h0, bank_q};
            ilod_pkg::OFF_RETTOP: rdMux = {16'h0, retTop_q};
            ilod_pkg::OFF_INSTR:  rdMux = {16'h0, instr_q};
            ilod_pkg::OFF_ADDR:   rdMux = {18'h0, mem_q.indexed, mem_q.destToW, mem_q.addr};
            ilod_pkg::OFF_PC:     rdMux = {16'h0, pc_q};
            ilod_pkg::OFF_STAT:   rdMux = {30'h0, lastRet_q, busy_q};
            default:              rdMux = 32'h0;
        endcase
    end

    // apb answer: no wait state, data captured in setup
    // capturing in setup keeps the read mux off the ready path
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_q  <= 32'h0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= apbSetup;
            pslverr_q <= apbSetup && !mapped;
            prdata_q  <= apbSetup && !pwrite ? rdMux : 32'h0;
        end
    end

    // software settings
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            extEn_q  <= ilod_pkg::EXT_RST;
            bank_q   <= ilod_pkg::BANK_RST;
            retTop_q <= ilod_pkg::RETTOP_RST;
            instr_q  <= 16'h0000;
        end else begin
            if (wrCtrl)    extEn_q  <= pwdata[ilod_pkg::CTRL_EXT_BIT];
            if (wrBank)    bank_q   <= pwdata[3:0];
            if (wrRet)     retTop_q <= pwdata[15:0];
            if (issueValid) instr_q <= issueWord;
        end
    end

    // frame pointer: the instruction update beats a software write
    // a racing software write is lost, so firmware must not overlap a return
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fp_q <= ilod_pkg::FP_RST;
        end else if (issueValid && isSubRet) begin
            fp_q <= fpSub;
        end else if (wrFp) begin
            fp_q <= pwdata[11:0];
        end
    end

    // return sequencing: second cycle idles and refuses issue
    // pc stands until the next return, so the core may load it late
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q    <= 1'b0;
            lastRet_q <= 1'b0;
            pcLoad_q  <= 1'b0;
            pc_q      <= ilod_pkg::PC_RST;
        end else begin
            busy_q   <= issueValid && isSubRet;
            pcLoad_q <= issueValid && isSubRet;
            if (issueValid) lastRet_q <= isSubRet;
            if (issueValid && isSubRet) pc_q <= retTop_q;
        end
    end

    // ready has its own flop so the output needs no gate behind it
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_q <= 1'b1;
        end else begin
            ready_q <= !(issueValid && isSubRet);
        end
    end

    // data memory request
    // address fields hold between pulses so software can read the last one
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_q <= '{valid: 1'b0, addr: ilod_pkg::ADDR_RST, destToW: 1'b0, indexed: 1'b0};
        end else begin
            mem_q.valid <= issueValid && isFileOp;
            if (issueValid && isFileOp) begin
                mem_q.addr    <= addrNext;
                mem_q.destToW <= toWNext;
                mem_q.indexed <= idxNext;
            end
        end
    end

    assign instrReady   = ready_q;
    assign memReq       = mem_q;
    assign pcLoad       = pcLoad_q;
    assign pcNext       = pc_q;
    assign framePointer = fp_q;
    assign prdata       = prdata_q;
    assign pready       = pready_q;
    assign pslverr      = pslverr_q;

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_fp_subtract: assert property (issueValid && isSubRet |=>
        fp_q == 12'($past(fp_q) - {6'h00, $past(lit)}))
        else $error("frame pointer not reduced by literal");

    a_return_pc: assert property (issueValid && isSubRet |=>
        pcLoad && pcNext == $past(retTop_q))
        else $error("return did not load pc from stack top");

    a_nop_cycle: assert property (issueValid && isSubRet |=>
        (!instrReady && !memReq.valid) ##1 instrReady)
        else $error("return second cycle not idle");

    a_select_field: assert property (issueValid && isPsub && !isSubRet && !wrFp |=>
        !pcLoad && $stable(fp_q))
        else $error("non-return pointer select acted as return");

    a_banked_abs: assert property (issueValid && isFileOp && !extEn_q
        && issueWord[ilod_pkg::ACC_BIT] |=> memReq.addr == {$past(bank_q), $past(issueWord[7:0])})
        else $error("banked address wrong");

    a_indexed_addr: assert property (issueValid && isFileOp && extEn_q
        && !issueWord[ilod_pkg::ACC_BIT] && issueWord[7:0] <= 8'h5f
        |=> memReq.indexed && memReq.addr == 12'($past(fp_q) + $past(issueWord[7:0])))
        else $error("indexed address wrong");

    a_large_abs: assert property (issueValid && isFileOp && !issueWord[ilod_pkg::ACC_BIT]
        && issueWord[7:0] > 8'h5f |=> !memReq.indexed && memReq.addr[11:8] == 4'hf)
        else $error("large operand not absolute");

    a_zero_fp: assert property (issueValid && isFileOp && fp_q == 12'h000
        && !issueWord[ilod_pkg::ACC_BIT] && issueWord[7:0] <= 8'h5f
        |=> memReq.addr == {4'h0, $past(issueWord[7:0])})
        else $error("zero pointer mismatch with access bank");

    a_dest_bit: assert property (issueValid && isFileOp && !isBitOp
        |=> memReq.destToW == !$past(issueWord[ilod_pkg::DEST_BIT]))
        else $error("destination select misrouted");

    a_mem_pulse: assert property (memReq.valid |-> $past(issueValid))
        else $error("memory request without issue");

    // apb answer timing: no wait state, a single-cycle strobe in the first access cycle
    a_apb_ready: assert property (apbSetup |=>
        pready && pslverr == !$past(mapped))
        else $error("apb answer missing after setup");

    a_apb_single: assert property (pready |=> !pready)
        else $error("apb ready held longer than one cycle");

    a_apb_wdata: assert property (apbSetup && pwrite |=> prdata == 32'h0)
        else $error("read data driven on a write");

    // return sequence: idle cycle, pc only moves on a return, pointer on a return or write
    a_busy_refuse: assert property (busy_q |=>
        !memReq.valid && !pcLoad && $stable(instr_q) && $stable(lastRet_q))
        else $error("issue taken in the idle return cycle");

    a_fp_hold: assert property (!(issueValid && isSubRet) && !wrFp |=>
        $stable(fp_q))
        else $error("frame pointer moved without a return or write");

    a_pc_hold: assert property (!(issueValid && isSubRet) |=>
        !pcLoad && $stable(pcNext))
        else $error("pc changed without a return");

    a_ret_flag: assert property (issueValid |=>
        lastRet_q == $past(isSubRet))
        else $error("return status flag wrong");

    // address forming across modes
    a_access_low: assert property (issueValid && isFileOp && !extEn_q
        && !issueWord[ilod_pkg::ACC_BIT] && issueWord[7:0] <= 8'h5f
        |=> !memReq.indexed && memReq.addr == {4'h0, $past(issueWord[7:0])})
        else $error("access bank low half wrong");

    a_std_absolute: assert property (issueValid && isFileOp && !extEn_q |=>
        !memReq.indexed)
        else $error("standard mode access marked indexed");

    a_ext_banked: assert property (issueValid && isFileOp && extEn_q
        && issueWord[ilod_pkg::ACC_BIT] |=> !memReq.indexed
        && memReq.addr == {$past(bank_q), $past(issueWord[7:0])})
        else $error("banked access indexed in extended mode");

    a_carry_bank: assert property (issueValid && isFileOp && idxNext
        && ({1'b0, fp_q[7:0]} + {1'b0, issueWord[7:0]}) > 9'h0ff
        |=> memReq.addr[11:8] == 4'($past(fp_q[11:8]) + 4'h1))
        else $error("offset carry lost");

    // request pulse and destination routing
    a_file_pulse: assert property (issueValid && isFileOp |=> memReq.valid)
        else $error("file operand access not requested");

    a_no_file: assert property (issueValid && !isFileOp |=> !memReq.valid)
        else $error("access requested for a non-file op");

    a_bit_dest: assert property (issueValid && isFileOp && isBitOp |=>
        !memReq.destToW)
        else $error("bit op result routed to working register");
endmodule : ilod_decode

// *** test/test_ilod_decode.sv ***
`timescale 1ns/1ps
module test_ilod_decode;
    logic                  ref_clk   = 1'b0;
    logic                  rst_n     = 1'b0;
    ilod_pkg::ilod_instr_t coreInstr = '0;
    logic                  instrReady;
    ilod_pkg::ilod_mem_t   memReq;
    logic                  pcLoad;
    logic [15:0]           pcNext;
    logic [11:0]           framePointer;
    logic                  psel      = 1'b0;
    logic                  penable   = 1'b0;
    logic                  pwrite    = 1'b0;
    logic [7:0]            paddr     = 8'h00;
    logic [31:0]           pwdata    = 32'h0;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           rd;
    int                    errors    = 0;
    int                    n_tests   = 0;
    int                    cycles    = 0;

    ilod_decode i_ilod_decode (.ref_clk(ref_clk), .rst_n(rst_n), .coreInstr(coreInstr),
        .instrReady(instrReady), .memReq(memReq), .pcLoad(pcLoad), .pcNext(pcNext),
        .framePointer(framePointer), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // free-running clock and a hang guard well above the expected run length
    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            errors = errors + 1;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       input logic expErr);
        int w;
        w = 0;
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            w++;
        end while (pready !== 1'b1);
        rd = prdata;
        check("pslverr", 32'(pslverr), 32'(expErr));
        check("apb wait", 32'(w), 32'h1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 1'b0);
        check(name, rd, exp);
    endtask : rd_chk

    // byte op with d and a bits, and a bit-set style op
    function automatic logic [15:0] byteOp(input logic d, input logic a, input logic [7:0] f);
        return {6'b001001, d, a, f};
    endfunction : byteOp

    function automatic logic [15:0] bitOp(input logic a, input logic [7:0] f);
        return {7'b1000000, a, f};
    endfunction : bitOp

    // issue one word; settle past the edge that registers the answer
    task automatic issue(input logic [15:0] w);
        @(posedge ref_clk);
        coreInstr <= '{valid: 1'b1, word: w};
        @(posedge ref_clk);
        coreInstr <= '0;
        #1;
    endtask : issue

    task automatic fop(input logic [15:0] w, input logic [11:0] eAddr, input logic eIdx,
                       input logic eToW);
        issue(w);
        check("memReq.valid", 32'(memReq.valid), 32'h1);
        check("memReq.addr", 32'(memReq.addr), 32'(eAddr));
        check("memReq.indexed", 32'(memReq.indexed), 32'(eIdx));
        check("memReq.destToW", 32'(memReq.destToW), 32'(eToW));
    endtask : fop

    initial begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        // reset values and two refused addresses
        rd_chk("ctrl", ilod_pkg::OFF_CTRL, 32'h0);
        rd_chk("fp", ilod_pkg::OFF_FP, 32'h0);
        check("instrReady", 32'(instrReady), 32'h1);
        apb(1'b0, 8'h20, 32'h0, 1'b1);
        check("unmapped", rd, 32'h0);
        apb(1'b0, 8'h06, 32'h0, 1'b1);
        check("unaligned", rd, 32'h0);
        $display("test reset done");
        // standard mode: access bank halves and banked access
        apb(1'b1, ilod_pkg::OFF_BANK, 32'h3, 1'b0);
        fop(byteOp(1'b1, 1'b0, 8'h20), 12'h020, 1'b0, 1'b0);
        fop(byteOp(1'b0, 1'b0, 8'h80), 12'hf80, 1'b0, 1'b1);
        fop(byteOp(1'b1, 1'b1, 8'h20), 12'h320, 1'b0, 1'b0);
        $display("test standard done");
        // extended mode; pointer near a bank edge so the carry matters
        apb(1'b1, ilod_pkg::OFF_CTRL, 32'h1, 1'b0);
        apb(1'b1, ilod_pkg::OFF_FP, 32'h1f0, 1'b0);
        fop(byteOp(1'b0, 1'b0, 8'h20), 12'h210, 1'b1, 1'b1);
        fop(byteOp(1'b1, 1'b0, 8'h5f), 12'h24f, 1'b1, 1'b0);
        fop(byteOp(1'b1, 1'b0, 8'h60), 12'hf60, 1'b0, 1'b0);
        fop(bitOp(1'b0, 8'h05), 12'h1f5, 1'b1, 1'b0);
        fop(byteOp(1'b1, 1'b1, 8'h20), 12'h320, 1'b0, 1'b0);
        apb(1'b1, ilod_pkg::OFF_FP, 32'h0, 1'b0);
        fop(byteOp(1'b1, 1'b0, 8'h30), 12'h030, 1'b1, 1'b0);
        apb(1'b1, ilod_pkg::OFF_INSTR, 32'(byteOp(1'b0, 1'b0, 8'h44)), 1'b0);
        #1;
        check("instr issue", 32'(memReq.valid), 32'h1);
        rd_chk("addr reg", ilod_pkg::OFF_ADDR, 32'h3044);
        rd_chk("instr reg", ilod_pkg::OFF_INSTR, 32'h2444);
        $display("test extended done");
        // subtract-and-return, then an issue in its idle cycle that must vanish
        apb(1'b1, ilod_pkg::OFF_FP, 32'h100, 1'b0);
        apb(1'b1, ilod_pkg::OFF_RETTOP, 32'habcd, 1'b0);
        @(posedge ref_clk);
        coreInstr <= '{valid: 1'b1, word: 16'he9e3};
        @(posedge ref_clk);
        coreInstr <= '{valid: 1'b1, word: byteOp(1'b1, 1'b0, 8'h10)};
        #1;
        check("pcLoad", 32'(pcLoad), 32'h1);
        check("pcNext", 32'(pcNext), 32'habcd);
        check("framePointer", 32'(framePointer), 32'h0dd);
        check("instrReady", 32'(instrReady), 32'h0);
        @(posedge ref_clk);
        coreInstr <= '0;
        #1;
        check("pcLoad idle", 32'(pcLoad), 32'h0);
        check("memReq idle", 32'(memReq.valid), 32'h0);
        check("instrReady", 32'(instrReady), 32'h1);
        rd_chk("fp", ilod_pkg::OFF_FP, 32'h0dd);
        rd_chk("stat", ilod_pkg::OFF_STAT, 32'h2);
        rd_chk("pc", ilod_pkg::OFF_PC, 32'habcd);
        // pointer select 10 leaves pointer and pc alone; largest literal
        issue(16'he9a3);
        check("pcLoad sel10", 32'(pcLoad), 32'h0);
        check("fp sel10", 32'(framePointer), 32'h0dd);
        issue(16'he9ff);
        check("fp k3f", 32'(framePointer), 32'h09e);
        check("pcLoad k3f", 32'(pcLoad), 32'h1);
        $display("test return done");
        give_verdict();
    end
endmodule : test_ilod_decode
